// >>> rtc_time_alarm_registers.v
// Notes on behaviour
// RULE1 - Seconds alarm holds 00-59 BCD or 00-3B
// RULE2 - Alarm byte with bits 7,6 set always matches
// RULE3 - Minutes count 00-59 BCD or 00-3B binary
// RULE4 - Minutes alarm 00-59 BCD, 00-3B, or wildcard
// RULE5 - 12-hour: 01-12/81-92 BCD, 01-0C/81-8C binary
// RULE6 - 24-hour: 00-23 BCD or 00-17 binary
// RULE7 - Hours alarm shares hours encoding, PM flag
// RULE8 - Weekday holds 01 through 07
// RULE9 - Date holds 01-31 BCD or 01-1F binary
// RULE10 - Month holds 01-12 BCD or 01-0C binary
// RULE11 - Seconds count 00-59 BCD or 00-3B binary
// RULE12 - Format bit: 0 BCD, 1 binary
// RULE13 - Hour bit: 0 twelve-hour, 1 twenty-four-hour
// RULE14 - Alarm pulses after update when seconds, minutes and hours all match
// RULE15 - Seconds tick carries through to month
`timescale 1ns/1ps
`include "rtc_time_consts.vh"

module rtc_time_alarm_registers #(
   parameter [31:0] TICK_CYCLES = `SECOND_NS / `CLK_PERIOD_NS
) (
   input  wire       REF_CLK_I,
   input  wire       RESET_N_I,
   input  wire       NUMBER_FORMAT_SELECT_I,
   input  wire       CLOCK_12_24_SELECT_I,
   input  wire       REG_WR_I,
   input  wire       REG_RD_I,
   input  wire [7:0] REG_INDEX_I,
   input  wire [7:0] REG_WDATA_I,
   output reg  [7:0] REG_RDATA_O,
   output reg        SECOND_TICK_O,
   output reg        ALARM_O
);

   reg  [1:0]  fmt_sync_ff;
   reg  [1:0]  hr_sync_ff;
   reg  [31:0] div_ff;
   reg  [7:0]  time_ss_ff;
   reg  [7:0]  alarm_ss_ff;
   reg  [7:0]  time_mm_ff;
   reg  [7:0]  alarm_mm_ff;
   reg  [7:0]  time_hh_ff;
   reg  [7:0]  alarm_hh_ff;
   reg  [7:0]  weekday_ff;
   reg  [7:0]  day_of_month_ff;
   reg  [7:0]  calendar_moy_ff;
   reg  [7:0]  nxt_ss;
   reg  [7:0]  nxt_mm;
   reg  [7:0]  nxt_hh;
   reg  [7:0]  nxt_wday;
   reg  [7:0]  nxt_dom;
   reg  [7:0]  nxt_moy;
   reg         c_ss;
   reg         c_mm;
   reg         c_hh;
   reg         c_dom;
   reg  [6:0]  hr12;
   wire        bin_mode;
   wire        h24_mode;
   wire        tick;
   wire        m_ss;
   wire        m_mm;
   wire        m_hh;

   assign bin_mode = fmt_sync_ff[1];                            // RULE12
   assign h24_mode = hr_sync_ff[1];                             // RULE13
   assign tick     = (div_ff == TICK_CYCLES - `DIV_STEP);

   // Increment in current format; BCD low nibble rolls at nine
   function [7:0] incr;
      input [7:0] v;
      input       bin;
      begin
         if (bin)
            incr = v + 8'h01;
         else if (v[3:0] >= `BCD_DIGIT_MAX)
            incr = {v[7:4] + 4'h1, 4'h0};
         else
            incr = v + 8'h01;
      end
   endfunction

   // Wildcard in bits 7,6 matches whatever the time holds
   function match;
      input [7:0] a;
      input [7:0] t;
      begin
         match = (a[7:6] == `DONT_CARE_PAT) || (a == t);        // RULE2
      end
   endfunction

   assign m_ss = match(alarm_ss_ff, nxt_ss);                    // RULE1
   assign m_mm = match(alarm_mm_ff, nxt_mm);                    // RULE4
   assign m_hh = match(alarm_hh_ff, nxt_hh);                    // RULE7

   always @* begin
      c_ss = time_ss_ff >= (bin_mode ? `MAX_MS_BIN : `MAX_MS_BCD);
      nxt_ss = c_ss ? `ZERO_BYTE : incr(time_ss_ff, bin_mode);  // RULE11
      c_mm = c_ss &&
             time_mm_ff >= (bin_mode ? `MAX_MS_BIN : `MAX_MS_BCD);
      nxt_mm = time_mm_ff;
      if (c_ss)
         nxt_mm = c_mm ? `ZERO_BYTE : incr(time_mm_ff, bin_mode); // RULE3
      // Hours: 24h wraps to 0; 12h runs 12,1..11 and flips PM at 11->12
      hr12 = time_hh_ff[6:0];
      nxt_hh = time_hh_ff;
      c_hh = 1'b0;
      if (c_mm) begin
         if (h24_mode) begin
            c_hh = time_hh_ff >= (bin_mode ? `MAX_H24_BIN : `MAX_H24_BCD);
            nxt_hh = c_hh ? `ZERO_BYTE : incr(time_hh_ff, bin_mode); // RULE6
         end else if (hr12 >= (bin_mode ? `MAX_H12_BIN : `MAX_H12_BCD)) begin
            nxt_hh = {time_hh_ff[`PM_BIT], `H12_FIRST};         // RULE5
         end else begin
            nxt_hh = incr({1'b0, hr12}, bin_mode);
            nxt_hh[`PM_BIT] = time_hh_ff[`PM_BIT];
            if (nxt_hh[6:0] == (bin_mode ? `MAX_H12_BIN : `MAX_H12_BCD)) begin
               nxt_hh[`PM_BIT] = ~time_hh_ff[`PM_BIT];          // RULE5
               c_hh = time_hh_ff[`PM_BIT];
            end
         end
      end
      // Calendar: no month-length table, date runs to its field limit
      nxt_wday = weekday_ff;
      nxt_dom  = day_of_month_ff;
      nxt_moy  = calendar_moy_ff;
      c_dom    = 1'b0;
      if (c_hh) begin
         nxt_wday = (weekday_ff >= `MAX_WDAY) ? `MIN_ONE :
                    incr(weekday_ff, bin_mode);                 // RULE8
         c_dom = day_of_month_ff >=
                 (bin_mode ? `MAX_DOM_BIN : `MAX_DOM_BCD);
         nxt_dom = c_dom ? `MIN_ONE :
                   incr(day_of_month_ff, bin_mode);             // RULE9
         if (c_dom)
            nxt_moy = (calendar_moy_ff >=
                      (bin_mode ? `MAX_MOY_BIN : `MAX_MOY_BCD)) ?
                      `MIN_ONE : incr(calendar_moy_ff, bin_mode); // RULE10
      end
   end

   always @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         fmt_sync_ff     <= `SYNC_RESET;
         hr_sync_ff      <= `SYNC_RESET;
         div_ff          <= `DIV_RESET;
         time_ss_ff      <= `REG_RESET;
         alarm_ss_ff     <= `REG_RESET;
         time_mm_ff      <= `REG_RESET;
         alarm_mm_ff     <= `REG_RESET;
         time_hh_ff      <= `REG_RESET;
         alarm_hh_ff     <= `REG_RESET;
         weekday_ff      <= `REG_RESET;
         day_of_month_ff <= `REG_RESET;
         calendar_moy_ff <= `REG_RESET;
         SECOND_TICK_O   <= 1'b0;
         ALARM_O         <= 1'b0;
      end else begin
         fmt_sync_ff   <= {fmt_sync_ff[0], NUMBER_FORMAT_SELECT_I};
         hr_sync_ff    <= {hr_sync_ff[0], CLOCK_12_24_SELECT_I};
         div_ff        <= tick ? `DIV_RESET : div_ff + `DIV_STEP;
         SECOND_TICK_O <= tick;
         ALARM_O       <= tick && m_ss && m_mm && m_hh;         // RULE14
         if (tick) begin                                        // RULE15
            time_ss_ff      <= nxt_ss;
            time_mm_ff      <= nxt_mm;
            time_hh_ff      <= nxt_hh;
            weekday_ff      <= nxt_wday;
            day_of_month_ff <= nxt_dom;
            calendar_moy_ff <= nxt_moy;
         end
         // Host write wins over a same-cycle tick for that byte
         if (REG_WR_I) begin
            if (REG_INDEX_I == `IDX_TIME_SS)
               time_ss_ff <= REG_WDATA_I;
            else if (REG_INDEX_I == `IDX_ALARM_SS)
               alarm_ss_ff <= REG_WDATA_I;
            else if (REG_INDEX_I == `IDX_TIME_MM)
               time_mm_ff <= REG_WDATA_I;
            else if (REG_INDEX_I == `IDX_ALARM_MM)
               alarm_mm_ff <= REG_WDATA_I;
            else if (REG_INDEX_I == `IDX_TIME_HH)
               time_hh_ff <= REG_WDATA_I;
            else if (REG_INDEX_I == `IDX_ALARM_HH)
               alarm_hh_ff <= REG_WDATA_I;
            else if (REG_INDEX_I == `IDX_WEEKDAY)
               weekday_ff <= REG_WDATA_I;
            else if (REG_INDEX_I == `IDX_DAY_OF_MONTH)
               day_of_month_ff <= REG_WDATA_I;
            else if (REG_INDEX_I == `IDX_CALENDAR_MOY)
               calendar_moy_ff <= REG_WDATA_I;
         end
      end
   end

   always @(posedge REF_CLK_I) begin
      if (!RESET_N_I)
         REG_RDATA_O <= `ZERO_BYTE;
      else if (REG_RD_I) begin
         if (REG_INDEX_I == `IDX_TIME_SS)
            REG_RDATA_O <= time_ss_ff;
         else if (REG_INDEX_I == `IDX_ALARM_SS)
            REG_RDATA_O <= alarm_ss_ff;
         else if (REG_INDEX_I == `IDX_TIME_MM)
            REG_RDATA_O <= time_mm_ff;
         else if (REG_INDEX_I == `IDX_ALARM_MM)
            REG_RDATA_O <= alarm_mm_ff;
         else if (REG_INDEX_I == `IDX_TIME_HH)
            REG_RDATA_O <= time_hh_ff;
         else if (REG_INDEX_I == `IDX_ALARM_HH)
            REG_RDATA_O <= alarm_hh_ff;
         else if (REG_INDEX_I == `IDX_WEEKDAY)
            REG_RDATA_O <= weekday_ff;
         else if (REG_INDEX_I == `IDX_DAY_OF_MONTH)
            REG_RDATA_O <= day_of_month_ff;
         else if (REG_INDEX_I == `IDX_CALENDAR_MOY)
            REG_RDATA_O <= calendar_moy_ff;
         else
            REG_RDATA_O <= `ZERO_BYTE;
      end
   end

endmodule // rtc_time_alarm_registers

// >>> rtc_time_consts.vh
`ifndef RTC_TIME_CONSTS_VH
`define RTC_TIME_CONSTS_VH

// Register indexes
`define IDX_TIME_SS      8'h00
`define IDX_ALARM_SS     8'h01
`define IDX_TIME_MM      8'h02
`define IDX_ALARM_MM     8'h03
`define IDX_TIME_HH      8'h04
`define IDX_ALARM_HH     8'h05
`define IDX_WEEKDAY      8'h06
`define IDX_DAY_OF_MONTH 8'h07
`define IDX_CALENDAR_MOY 8'h08

`define REG_RESET        8'h00

// Field limits, BCD and binary forms
`define MAX_MS_BCD       8'h59
`define MAX_MS_BIN       8'h3b
`define MAX_H24_BCD      8'h23
`define MAX_H24_BIN      8'h17
`define MAX_H12_BCD      7'h12
`define MAX_H12_BIN      7'h0c
`define MAX_WDAY         8'h07
`define MAX_DOM_BCD      8'h31
`define MAX_DOM_BIN      8'h1f
`define MAX_MOY_BCD      8'h12
`define MAX_MOY_BIN      8'h0c
`define MIN_ONE          8'h01
`define ZERO_BYTE        8'h00
`define SYNC_RESET       2'b00
`define DIV_RESET        32'h0
`define DIV_STEP         32'h1
`define H12_FIRST        7'h01
`define BCD_DIGIT_MAX    4'h9

// Hours byte layout
`define PM_BIT           7
`define DONT_CARE_PAT    2'b11

// One-second tick counted directly in 100 MHz cycles
`define SECOND_NS        1000000000
`define CLK_PERIOD_NS    10

`endif

// >>> rtc_time_alarm_registers_asserts.sv
`timescale 1ns/1ps
module rtc_time_alarm_registers_asserts #(
   parameter [31:0] TICK_CYCLES = 32'd40
) (
   input wire       REF_CLK_I,
   input wire       RESET_N_I,
   input wire       NUMBER_FORMAT_SELECT_I,
   input wire       CLOCK_12_24_SELECT_I,
   input wire       REG_WR_I,
   input wire       REG_RD_I,
   input wire [7:0] REG_INDEX_I,
   input wire [7:0] REG_WDATA_I,
   input wire [7:0] REG_RDATA_O,
   input wire       SECOND_TICK_O,
   input wire       ALARM_O
);
   reg [31:0] cnt_ff;
   reg        seen_ff;
   // Spacing only judged after the first tick; its offset is not checked
   always @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         cnt_ff  <= 32'h0;
         seen_ff <= 1'b0;
      end else begin
         cnt_ff  <= SECOND_TICK_O ? 32'h0 : cnt_ff + 32'h1;
         seen_ff <= seen_ff | SECOND_TICK_O;
      end
   end
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   chk_alarm_on_tick: assert property (ALARM_O |-> SECOND_TICK_O)
      else $error("alarm pulse outside a tick");
   chk_tick_period: assert property (seen_ff && SECOND_TICK_O
      |-> cnt_ff == TICK_CYCLES - 1) else $error("tick spacing wrong");
   chk_tick_due: assert property (seen_ff |-> cnt_ff < TICK_CYCLES)
      else $error("tick overdue");
   chk_tick_single: assert property (SECOND_TICK_O |=> !SECOND_TICK_O)
      else $error("tick pulse too long");
   chk_rdata_hold: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
      else $error("read data changed without a read");
   chk_unmapped_zero: assert property (REG_RD_I && REG_INDEX_I > 8'h08
      |=> REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
   chk_alarm_readback: assert property (REG_RD_I && REG_INDEX_I == 8'h01
      && $past(REG_WR_I, 2) && $past(REG_INDEX_I, 2) == 8'h01
      |=> REG_RDATA_O == $past(REG_WDATA_I, 3)) else $error("readback wrong");
   chk_reset_quiet: assert property (disable iff (1'b0) !RESET_N_I
      |=> !ALARM_O && !SECOND_TICK_O && REG_RDATA_O == 8'h00)
      else $error("outputs active in reset");
endmodule // rtc_time_alarm_registers_asserts

// >>> rtc_time_alarm_registers_bench.sv
`timescale 1ns/1ps
module rtc_time_alarm_registers_bench;
   localparam [31:0] TICKS = 32'd40;
   reg        clk;
   reg        rst_n;
   reg        fmt;
   reg        h24;
   reg        wr;
   reg        rd;
   reg  [7:0] idx;
   reg  [7:0] wdata;
   wire [7:0] rdata;
   wire       tick;
   wire       alarm;
   integer    mismatches;
   integer    num_checks;
   integer    i;
   rtc_time_alarm_registers #(.TICK_CYCLES(TICKS)) i_dut (
      .REF_CLK_I(clk), .RESET_N_I(rst_n), .NUMBER_FORMAT_SELECT_I(fmt),
      .CLOCK_12_24_SELECT_I(h24), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_INDEX_I(idx), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
      .SECOND_TICK_O(tick), .ALARM_O(alarm));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task check(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Two cycles per access so the strobe never toggles twice in one step
   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         wr <= 1'b1;
         idx <= a;
         wdata <= d;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rd_reg(input [7:0] a, input [7:0] exp);
      begin
         @(posedge clk);
         rd <= 1'b1;
         idx <= a;
         @(posedge clk);
         rd <= 1'b0;
         #1 check(rdata, exp);
      end
   endtask
   task sync;
      integer n;
      begin
         n = 0;
         @(negedge clk);
         while (tick !== 1'b1 && n < 200) begin
            @(negedge clk);
            n = n + 1;
         end
         check({7'h0, tick}, 8'h01);
      end
   endtask
   // Every field at its top value, so one tick carries through to month
   task run_case(input f, input h, input [7:0] ms, input [7:0] hh,
                 input [7:0] hx, input [7:0] dm, input [7:0] mo);
      begin
         @(posedge clk);
         fmt <= f;
         h24 <= h;
         sync;
         sync;
         wr_reg(8'h00, ms);
         wr_reg(8'h02, ms);
         wr_reg(8'h04, hh);
         wr_reg(8'h06, 8'h07);
         wr_reg(8'h07, dm);
         wr_reg(8'h08, mo);
         wr_reg(8'h03, 8'h00);
         wr_reg(8'h05, hx);
         wr_reg(8'h01, 8'h00);
         rd_reg(8'h01, 8'h00);
         sync;
         check({7'h0, alarm}, 8'h01);
         rd_reg(8'h00, 8'h00);
         rd_reg(8'h02, 8'h00);
         rd_reg(8'h04, hx);
         rd_reg(8'h06, 8'h01);
         rd_reg(8'h07, 8'h01);
         rd_reg(8'h08, 8'h01);
      end
   endtask
   // Hour turns inside one day, BCD 12-hour; weekday must not move
   task run_hour(input [7:0] hh, input [7:0] hx);
      begin
         @(posedge clk);
         fmt <= 1'b0;
         h24 <= 1'b0;
         sync;
         sync;
         wr_reg(8'h00, 8'h59);
         wr_reg(8'h02, 8'h59);
         wr_reg(8'h04, hh);
         wr_reg(8'h06, 8'h03);
         wr_reg(8'h01, 8'h00);
         wr_reg(8'h03, 8'h00);
         wr_reg(8'h05, hx);
         sync;
         check({7'h0, alarm}, 8'h01);
         rd_reg(8'h04, hx);
         rd_reg(8'h06, 8'h03);
      end
   endtask
   task summarize;
      begin
         $display("checks=%0d mismatches=%0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #60000;
      mismatches = mismatches + 1;
      summarize;
   end
   initial begin
      mismatches = 0;
      num_checks = 0;
      rst_n = 1'b0;
      fmt = 1'b0;
      h24 = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      idx = 8'h00;
      wdata = 8'h00;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 9; i = i + 1)
         rd_reg(i[7:0], 8'h00);
      wr_reg(8'h09, 8'hff);
      rd_reg(8'h09, 8'h00);
      run_case(1'b0, 1'b0, 8'h59, 8'h91, 8'h12, 8'h31, 8'h12);
      run_case(1'b1, 1'b0, 8'h3b, 8'h8b, 8'h0c, 8'h1f, 8'h0c);
      run_case(1'b0, 1'b1, 8'h59, 8'h23, 8'h00, 8'h31, 8'h12);
      run_case(1'b1, 1'b1, 8'h3b, 8'h17, 8'h00, 8'h1f, 8'h0c);
      run_hour(8'h11, 8'h92);
      run_hour(8'h92, 8'h81);
      wr_reg(8'h01, 8'hc0);
      wr_reg(8'h03, 8'hc0);
      wr_reg(8'h05, 8'hc0);
      sync;
      check({7'h0, alarm}, 8'h01);
      wr_reg(8'h05, 8'h05);
      sync;
      check({7'h0, alarm}, 8'h00);
      summarize;
   end
endmodule // rtc_time_alarm_registers_bench

bind rtc_time_alarm_registers rtc_time_alarm_registers_asserts #(
   .TICK_CYCLES(TICK_CYCLES)) u_chk (
   .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
   .NUMBER_FORMAT_SELECT_I(NUMBER_FORMAT_SELECT_I),
   .CLOCK_12_24_SELECT_I(CLOCK_12_24_SELECT_I), .REG_WR_I(REG_WR_I),
   .REG_RD_I(REG_RD_I), .REG_INDEX_I(REG_INDEX_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
   .SECOND_TICK_O(SECOND_TICK_O), .ALARM_O(ALARM_O));
